// *** src/ssq_pkg.sv ***
/*
 * Shared constants and types of the sequence set advance controller.
 * Assumes a 200 MHz clock and an AXI4-Lite register bus with 32-bit data.
 */
`default_nettype none

package ssq_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned LINE_BLANK_NS  = 100;
   localparam int unsigned LINE_BLANK_CYC = (LINE_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BLANK_W        = 8;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned MAX_SETS = 64;
   localparam int unsigned IDX_W    = 6;
   localparam int unsigned CNT_W    = 7;
   localparam int unsigned PARAM_W  = 32;
   localparam int unsigned AXI_AW   = 8;
   localparam int unsigned AXI_DW   = 32;
   localparam int unsigned CTRL_W   = 7;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [AXI_AW-1:0] OFF_CTRL   = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_COUNT  = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_SEL    = 8'h0C;
   localparam logic [AXI_AW-1:0] OFF_DATA   = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_BASE   = 8'h14;
   localparam logic [AXI_AW-1:0] OFF_ACTIVE = 8'h18;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_EN_BIT      = 0;
   localparam int unsigned CTRL_SRC_LSB     = 1;
   localparam int unsigned CTRL_RST_EN_BIT  = 3;
   localparam int unsigned CTRL_RST_SEL_BIT = 4;
   localparam int unsigned CTRL_INV1_BIT    = 5;
   localparam int unsigned CTRL_INV2_BIT    = 6;
   localparam int unsigned STAT_WAIT_BIT    = 8;
   localparam int unsigned STAT_EN_BIT      = 9;

   localparam logic [CTRL_W-1:0]  CTRL_RESET  = 7'h00;
   localparam logic [CNT_W-1:0]   COUNT_RESET = 7'h01;
   localparam logic [CNT_W-1:0]   COUNT_MIN   = 7'h01;
   localparam logic [CNT_W-1:0]   COUNT_MAX   = 7'h40;
   localparam logic [IDX_W-1:0]   IDX_FIRST   = 6'h00;
   localparam logic [PARAM_W-1:0] BASE_RESET  = 32'h00000000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_ALWAYS = 2'b00,
      SRC_LINE1  = 2'b01,
      SRC_LINE2  = 2'b10,
      SRC_NONE   = 2'b11
   } ssq_src_type;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_LOAD = 2'b01,
      ST_WAIT = 2'b10
   } ssq_state_type;

endpackage

`default_nettype wire

// *** src/ssq_set_mem.sv ***
/*
 * Storage of the sequence sets: one write port and two registered read ports.
 * Assumes all ports share one clock; read data appear one edge after the address.
 */
`timescale 1ns/1ps
`default_nettype none

module ssq_set_mem #(
   parameter int unsigned DATA_W = 32,
   parameter int unsigned DEPTH  = 64,
   parameter int unsigned ADDR_W = 6
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic [ADDR_W-1:0] ra_addr,
   output      logic [DATA_W-1:0] ra_data,
   input  wire logic [ADDR_W-1:0] rb_addr,
   output      logic [DATA_W-1:0] rb_data
);

   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ra_data <= '0;
         rb_data <= '0;
      end else begin
         ra_data <= mem[ra_addr];
         rb_data <= mem[rb_addr];
      end
   end

endmodule

`default_nettype wire

// *** src/ssq_ctrl.sv ***
/*
 * Sequence set advance controller with AXI4-Lite registers.
 * Assumes frame_trigger, line1_in and line2_in are synchronous to aclk.
 */
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
// Summary of operation
// - On enable a new cycle starts by loading set 0 into the active set.
// - Free-running source advances one set per trigger; first trigger uses set 1.
// - Set count bounds indices from zero to count minus one.
// - After the last index the next advance wraps to set 0.
// - Line 1 or line 2 is selectable as synchronous restart source.
// - Restart line high at a trigger restarts the cycle using set 0.
// - Restart beats advance on the same trigger.
// - Triggers count on their rising edge; decisions are taken there.
// - Line 1 or line 2 may gate advance; order stays ascending.
// - Gate line low at a trigger keeps the current set, loads nothing.
// - Gate line high at a trigger loads the next set.
// - While a line changes, waiting drops and triggers are ignored.
// - Disable stops cycling and restores the pre-enable parameters.
// - Set count accepts at most sixty-four sets.
`timescale 1ns/1ps
`default_nettype none

module ssq_ctrl #(
   parameter int unsigned DEPTH = ssq_pkg::MAX_SETS
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [ssq_pkg::AXI_AW-1:0]  s_axil_awaddr,
   input  wire logic                        s_axil_awvalid,
   output      logic                        s_axil_awready,
   input  wire logic [ssq_pkg::AXI_DW-1:0]  s_axil_wdata,
   input  wire logic [3:0]                  s_axil_wstrb,
   input  wire logic                        s_axil_wvalid,
   output      logic                        s_axil_wready,
   output      logic [1:0]                  s_axil_bresp,
   output      logic                        s_axil_bvalid,
   input  wire logic                        s_axil_bready,
   input  wire logic [ssq_pkg::AXI_AW-1:0]  s_axil_araddr,
   input  wire logic                        s_axil_arvalid,
   output      logic                        s_axil_arready,
   output      logic [ssq_pkg::AXI_DW-1:0]  s_axil_rdata,
   output      logic [1:0]                  s_axil_rresp,
   output      logic                        s_axil_rvalid,
   input  wire logic                        s_axil_rready,
   input  wire logic                        frame_trigger,
   input  wire logic                        line1_in,
   input  wire logic                        line2_in,
   output      logic [ssq_pkg::PARAM_W-1:0] active_params,
   output      logic [ssq_pkg::IDX_W-1:0]   active_index,
   output      logic                        waiting_for_trigger,
   output      logic                        frame_accept,
   output      logic                        seq_enabled
);

   import ssq_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [AXI_AW-1:0]  waddr_reg;
   logic [AXI_DW-1:0]  wdata_reg;
   logic [3:0]         wstrb_reg;
   logic [CTRL_W-1:0]  ctrl_reg;
   logic [CNT_W-1:0]   count_reg;
   logic [IDX_W-1:0]   sel_reg;
   logic [PARAM_W-1:0] base_reg;
   logic [IDX_W-1:0]   idx_reg;
   logic [BLANK_W-1:0] blank_reg;
   logic [BLANK_W-1:0] blank_next;
   logic               trig_prev_reg;
   logic               l1_prev_reg;
   logic               l2_prev_reg;
   ssq_state_type      state_reg;
   ssq_state_type      state_next;
   logic [PARAM_W-1:0] mem_seq_data;
   logic [PARAM_W-1:0] mem_sw_data;
   logic [IDX_W-1:0]   target_idx;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
                                               input logic [AXI_DW-1:0] data,
                                               input logic [3:0]        strb);
      logic [AXI_DW-1:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction

   wire aw_take  = s_axil_awvalid && s_axil_awready;
   wire w_take   = s_axil_wvalid && s_axil_wready;
   wire ar_take  = s_axil_arvalid && s_axil_arready;
   wire do_write = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;
   wire hit_ctrl  = (waddr_reg == OFF_CTRL);
   wire hit_count = (waddr_reg == OFF_COUNT);
   wire hit_sel   = (waddr_reg == OFF_SEL);
   wire hit_data  = (waddr_reg == OFF_DATA);
   wire hit_base  = (waddr_reg == OFF_BASE);
   wire wr_ok     = hit_ctrl || hit_count || hit_sel || hit_data || hit_base;
   wire [AXI_DW-1:0] ctrl_wr  = merge(AXI_DW'(ctrl_reg), wdata_reg, wstrb_reg);
   wire [AXI_DW-1:0] count_wr = merge(AXI_DW'(count_reg), wdata_reg, wstrb_reg);
   wire [AXI_DW-1:0] sel_wr   = merge(AXI_DW'(sel_reg), wdata_reg, wstrb_reg);
   wire [AXI_DW-1:0] data_wr  = merge(mem_sw_data, wdata_reg, wstrb_reg);
   wire [AXI_DW-1:0] base_wr  = merge(base_reg, wdata_reg, wstrb_reg);
   wire [CNT_W-1:0] count_clamp = (count_wr == '0) ? COUNT_MIN :
                                  (count_wr > AXI_DW'(COUNT_MAX)) ? COUNT_MAX :
                                  count_wr[CNT_W-1:0];
   wire [AXI_DW-1:0] status_word = AXI_DW'(idx_reg)
                                 | (AXI_DW'(waiting_for_trigger) << STAT_WAIT_BIT)
                                 | (AXI_DW'(seq_enabled) << STAT_EN_BIT);
   wire rd_ctrl   = (s_axil_araddr == OFF_CTRL);
   wire rd_count  = (s_axil_araddr == OFF_COUNT);
   wire rd_status = (s_axil_araddr == OFF_STATUS);
   wire rd_sel    = (s_axil_araddr == OFF_SEL);
   wire rd_data   = (s_axil_araddr == OFF_DATA);
   wire rd_base   = (s_axil_araddr == OFF_BASE);
   wire rd_active = (s_axil_araddr == OFF_ACTIVE);
   wire rd_ok     = rd_ctrl || rd_count || rd_status || rd_sel || rd_data
                 || rd_base || rd_active;

   wire [AXI_DW-1:0] rd_mux = rd_ctrl   ? AXI_DW'(ctrl_reg)  :
                              rd_count  ? AXI_DW'(count_reg) :
                              rd_status ? status_word        :
                              rd_sel    ? AXI_DW'(sel_reg)   :
                              rd_data   ? mem_sw_data        :
                              rd_base   ? base_reg           :
                              rd_active ? active_params      : '0;

   // ----------------------------------------------------------------
   // Bus channels
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_awready <= 1'b1;
         s_axil_wready  <= 1'b1;
         s_axil_bvalid  <= 1'b0;
         s_axil_bresp   <= RESP_OKAY;
         waddr_reg      <= '0;
         wdata_reg      <= '0;
         wstrb_reg      <= '0;
      end else begin
         if (aw_take) begin
            s_axil_awready <= 1'b0;
            waddr_reg      <= s_axil_awaddr;
         end
         if (w_take) begin
            s_axil_wready <= 1'b0;
            wdata_reg     <= s_axil_wdata;
            wstrb_reg     <= s_axil_wstrb;
         end
         if (do_write) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axil_bvalid && s_axil_bready) begin
            s_axil_bvalid  <= 1'b0;
            s_axil_awready <= 1'b1;
            s_axil_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_arready <= 1'b1;
         s_axil_rvalid  <= 1'b0;
         s_axil_rdata   <= '0;
         s_axil_rresp   <= RESP_OKAY;
      end else if (ar_take) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b1;
         s_axil_rdata   <= rd_mux;
         s_axil_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_rvalid && s_axil_rready) begin
         s_axil_rvalid  <= 1'b0;
         s_axil_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg  <= CTRL_RESET;
         count_reg <= COUNT_RESET;
         sel_reg   <= IDX_FIRST;
         base_reg  <= BASE_RESET;
      end else if (do_write) begin
         if (hit_ctrl) begin
            ctrl_reg <= ctrl_wr[CTRL_W-1:0];
         end
         if (hit_count) begin
            count_reg <= count_clamp;
         end
         if (hit_sel) begin
            sel_reg <= sel_wr[IDX_W-1:0];
         end
         if (hit_base) begin
            base_reg <= base_wr;
         end
      end
   end

   ssq_set_mem #(
      .DATA_W (PARAM_W),
      .DEPTH  (DEPTH),
      .ADDR_W (IDX_W)
   ) u_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (do_write && hit_data),
      .wr_addr (sel_reg),
      .wr_data (data_wr),
      .ra_addr (target_idx),
      .ra_data (mem_seq_data),
      .rb_addr (sel_reg),
      .rb_data (mem_sw_data)
   );

   // ----------------------------------------------------------------
   // Trigger and line decisions
   // ----------------------------------------------------------------
   ssq_src_type src;
   assign src = ssq_src_type'(ctrl_reg[CTRL_SRC_LSB +: 2]);

   wire enable    = ctrl_reg[CTRL_EN_BIT];
   wire eff1      = line1_in ^ ctrl_reg[CTRL_INV1_BIT];
   wire eff2      = line2_in ^ ctrl_reg[CTRL_INV2_BIT];
   wire rst_level = ctrl_reg[CTRL_RST_EN_BIT]
                 && (ctrl_reg[CTRL_RST_SEL_BIT] ? eff2 : eff1);
   wire adv_level = (src == SRC_ALWAYS) ? 1'b1 :
                    (src == SRC_LINE1)  ? eff1 :
                    (src == SRC_LINE2)  ? eff2 : 1'b0;

   wire line_change = (line1_in != l1_prev_reg) || (line2_in != l2_prev_reg);
   wire trig_rise   = frame_trigger && !trig_prev_reg;
   wire trig_ok     = trig_rise && waiting_for_trigger && !line_change
                   && enable && (state_reg == ST_WAIT);

   wire [CNT_W-1:0] idx_inc  = CNT_W'(idx_reg) + CNT_W'(1);
   wire [IDX_W-1:0] next_idx = (idx_inc >= count_reg) ? IDX_FIRST
                                                      : idx_inc[IDX_W-1:0];

   assign target_idx = (state_reg == ST_OFF) ? IDX_FIRST :
                       rst_level ? IDX_FIRST :
                       adv_level ? next_idx  :
                       idx_reg;
   wire do_load = trig_ok && (rst_level || adv_level);

   assign blank_next = line_change ? BLANK_W'(LINE_BLANK_CYC) :
                       (blank_reg != '0) ? blank_reg - BLANK_W'(1) : blank_reg;

   // ----------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (enable) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_next = enable ? ST_WAIT : ST_OFF;
         end
         ST_WAIT: begin
            if (!enable) begin
               state_next = ST_OFF;
            end else if (do_load) begin
               state_next = ST_LOAD;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg     <= ST_OFF;
         idx_reg       <= IDX_FIRST;
         blank_reg     <= '0;
         trig_prev_reg <= 1'b0;
         l1_prev_reg   <= 1'b0;
         l2_prev_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         blank_reg     <= blank_next;
         trig_prev_reg <= frame_trigger;
         l1_prev_reg   <= line1_in;
         l2_prev_reg   <= line2_in;
         if (state_reg == ST_OFF) begin
            idx_reg <= IDX_FIRST;
         end else if (do_load) begin
            idx_reg <= target_idx;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_params       <= BASE_RESET;
         active_index        <= IDX_FIRST;
         waiting_for_trigger <= 1'b0;
         frame_accept        <= 1'b0;
         seq_enabled         <= 1'b0;
      end else begin
         if (state_reg == ST_LOAD && enable) begin
            active_params <= mem_seq_data;
         end else if (state_next == ST_OFF) begin
            active_params <= base_reg;
         end
         active_index        <= (state_next == ST_OFF) ? IDX_FIRST
                              : (do_load ? target_idx : idx_reg);
         waiting_for_trigger <= (state_next == ST_WAIT) && (blank_next == '0);
         frame_accept        <= trig_ok;
         seq_enabled         <= (state_next != ST_OFF);
      end
   end

endmodule

`default_nettype wire

// *** testbench/ssq_ctrl_props.sv ***
/*
 * Assertions on the trigger side of the sequence set controller.
 * Assumes one clock and a synchronous active-low reset; bound to ssq_ctrl.
 */
`timescale 1ns/1ps
`default_nettype none

module ssq_ctrl_props #(
   parameter int unsigned DEPTH = 64
) (
   input wire logic                        aclk,
   input wire logic                        aresetn,
   input wire logic                        frame_trigger,
   input wire logic                        line1_in,
   input wire logic                        line2_in,
   input wire logic [ssq_pkg::PARAM_W-1:0] active_params,
   input wire logic [ssq_pkg::IDX_W-1:0]   active_index,
   input wire logic                        waiting_for_trigger,
   input wire logic                        frame_accept,
   input wire logic                        seq_enabled
);
   import ssq_pkg::*;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   sequence s_rise_taken;
      $past(frame_trigger) && !$past(frame_trigger, 2) && $past(waiting_for_trigger);
   endsequence

   sequence s_blank;
      !waiting_for_trigger [*8];
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_accept_on_edge: assert property (frame_accept |-> s_rise_taken)
      else $error("accept without a taken trigger edge");
   a_accept_pulse: assert property (frame_accept |=> !frame_accept)
      else $error("accept lasts more than one cycle");
   a_line_blank: assert property
      (($changed(line1_in) || $changed(line2_in)) |-> ##2 s_blank)
      else $error("waiting shown while a line changes");
   a_enable_wait: assert property
      ($rose(seq_enabled) |-> active_index == 6'h00 ##[1:30] waiting_for_trigger)
      else $error("enable does not start at set 0 and wait");
   a_off_quiet: assert property
      (!seq_enabled |-> !waiting_for_trigger && !frame_accept && active_index == 6'h00)
      else $error("sequencer active while off");
   a_index_range: assert property (active_index < DEPTH)
      else $error("index beyond storage");
   a_step_order: assert property (frame_accept |-> active_index == 6'h00
      || active_index == $past(active_index) || active_index == $past(active_index) + 6'h01)
      else $error("index does not step in ascending order");
   a_hold_params: assert property
      (frame_accept && active_index == $past(active_index) |=> $stable(active_params))
      else $error("parameters change on a hold");
   a_load_busy: assert property
      (frame_accept && active_index != $past(active_index) |-> !waiting_for_trigger)
      else $error("waiting shown while loading");
endmodule

bind ssq_ctrl ssq_ctrl_props #(.DEPTH(DEPTH)) i_ssq_ctrl_props (
   .aclk, .aresetn, .frame_trigger, .line1_in, .line2_in, .active_params,
   .active_index, .waiting_for_trigger, .frame_accept, .seq_enabled);

`default_nettype wire

// *** testbench/ssq_trig_src.sv ***
/*
 * Model of the outside party: drives the input lines and the frame trigger.
 * Assumes a 200 MHz clock; tasks are called right after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ssq_trig_src (
   input  wire logic aclk,
   input  wire logic waiting_for_trigger,
   output var  logic frame_trigger,
   output var  logic line1_in,
   output var  logic line2_in
);
   localparam int SETTLE = 200;

   initial begin
      frame_trigger = 1'b0;
      line1_in      = 1'b0;
      line2_in      = 1'b0;
   end

   // Sets the lines, then fires one trigger; a rude call fires during the line change.
   task automatic fire(input logic a, input logic b, input bit rude);
      int n;
      n = 0;
      @(posedge aclk);
      line1_in <= a;
      line2_in <= b;
      if (rude) begin
         repeat (2) @(posedge aclk);
      end else begin
         repeat (SETTLE) @(posedge aclk);
         while (waiting_for_trigger !== 1'b1 && n < 1000) begin
            @(posedge aclk);
            n++;
         end
      end
      frame_trigger <= 1'b1;
      repeat (2) @(posedge aclk);
      frame_trigger <= 1'b0;
      repeat (SETTLE) @(posedge aclk);
   endtask
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Self-checking bench of the sequence set controller.
 * Assumes ssq_pkg, ssq_ctrl, its checker and the trigger source model.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
   import ssq_pkg::*;

   logic        aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
   logic        s_axil_rvalid, s_axil_rready, frame_trigger, line1_in, line2_in;
   logic        waiting_for_trigger, frame_accept, seq_enabled;
   logic [7:0]  s_axil_awaddr, s_axil_araddr;
   logic [31:0] s_axil_wdata, s_axil_rdata, active_params, base, seed, e_par;
   logic [31:0] set_mem [6];
   logic [3:0]  s_axil_wstrb;
   logic [1:0]  s_axil_bresp, s_axil_rresp;
   logic [5:0]  active_index, e_idx;
   logic [37:0] exp_q [$];
   int          mismatches, samples_checked, cycles, idx, cnt, src;
   bit          inv;

   ssq_ctrl i_ssq_ctrl (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
      .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
      .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
      .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .frame_trigger,
      .line1_in, .line2_in, .active_params, .active_index, .waiting_for_trigger,
      .frame_accept, .seq_enabled);

   ssq_trig_src i_ssq_trig_src (.aclk, .waiting_for_trigger, .frame_trigger, .line1_in,
      .line2_in);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      bit ad, wd;
      @(posedge aclk);
      ad = 0;
      wd = 0;
      s_axil_awaddr  <= a;
      s_axil_wdata   <= d;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid  <= 1'b1;
      s_axil_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axil_awready && !ad) begin
            ad = 1;
            s_axil_awvalid <= 1'b0;
         end
         if (s_axil_wready && !wd) begin
            wd = 1;
            s_axil_wvalid <= 1'b0;
         end
      end while (s_axil_bvalid !== 1'b1);
      s_axil_bready <= 1'b0;
      check("bresp", {30'h0, s_axil_bresp}, {30'h0, e});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      bit at;
      @(posedge aclk);
      at = 0;
      s_axil_araddr  <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axil_arready && !at) begin
            at = 1;
            s_axil_arvalid <= 1'b0;
         end
      end while (s_axil_rvalid !== 1'b1);
      s_axil_rready <= 1'b0;
      check("rdata", s_axil_rdata, d);
      check("rresp", {30'h0, s_axil_rresp}, {30'h0, e});
   endtask

   // Works out the lines and the expected set, notes it, then fires.
   task automatic trig(input bit g, input bit r);
      logic a, b;
      a = (src == 1) ? (g ^ inv) : r;
      b = (src == 2) ? (g ^ inv) : ((src == 1) ? r : 1'b0);
      if (r)
         idx = 0;
      else if (src == 0 || g)
         idx = (idx + 1) % cnt;
      exp_q.push_back({idx[5:0], set_mem[idx]});
      i_ssq_trig_src.fire(a, b, 1'b0);
   endtask

   task automatic run(input int s, input bit v, input int c, input logic [15:0] g,
                      input logic [15:0] r, input int n, input bit rude);
      src = s;
      inv = v;
      cnt = c;
      idx = 0;
      wr(OFF_COUNT, c, RESP_OKAY);
      wr(OFF_CTRL, 32'h9 | (s << 1) | ((s == 1) << 4) | (v << (4 + s)), RESP_OKAY);
      rd(OFF_STATUS, 32'h300, RESP_OKAY);
      rd(OFF_ACTIVE, set_mem[0], RESP_OKAY);
      for (int k = 0; k < n; k++)
         trig(g[k], r[k]);
      if (rude) begin
         i_ssq_trig_src.fire(line1_in, ~line2_in, 1'b1);
         trig(1'b1, 1'b0);
      end
      wr(OFF_CTRL, 0, RESP_OKAY);
      rd(OFF_ACTIVE, base, RESP_OKAY);
      rd(OFF_STATUS, 0, RESP_OKAY);
   endtask

   // ----------------------------------------------------------------
   // Result watcher and timeout
   // ----------------------------------------------------------------
   initial forever begin
      @(posedge aclk);
      #1;
      if (frame_accept === 1'b1) begin
         if (exp_q.size() == 0)
            check("accept", 1, 0);
         else begin
            {e_idx, e_par} = exp_q.pop_front();
            check("index", {26'h0, active_index}, {26'h0, e_idx});
            @(posedge aclk);
            #1;
            check("params", active_params, e_par);
         end
      end
   end

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         stop_test;
      end
   end

   initial begin
      aresetn        = 1'b0;
      s_axil_awaddr  = 8'h00;
      s_axil_awvalid = 1'b0;
      s_axil_wdata   = 32'h00000000;
      s_axil_wstrb   = 4'hF;
      s_axil_wvalid  = 1'b0;
      s_axil_bready  = 1'b0;
      s_axil_araddr  = 8'h00;
      s_axil_arvalid = 1'b0;
      s_axil_rready  = 1'b0;
      seed           = 32'h4C76708F;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_CTRL, 0, RESP_OKAY);
      rd(OFF_COUNT, 1, RESP_OKAY);
      wr(OFF_COUNT, 0, RESP_OKAY);
      rd(OFF_COUNT, 1, RESP_OKAY);
      wr(OFF_COUNT, 32'h7F, RESP_OKAY);
      rd(OFF_COUNT, 32'h40, RESP_OKAY);
      wr(OFF_ACTIVE, 32'h1, RESP_SLVERR);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, 0, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         set_mem[i] = seed;
         wr(OFF_SEL, i, RESP_OKAY);
         wr(OFF_DATA, seed, RESP_OKAY);
      end
      rd(OFF_DATA, set_mem[5], RESP_OKAY);
      base = lfsr(seed);
      wr(OFF_BASE, base, RESP_OKAY);
      rd(OFF_ACTIVE, base, RESP_OKAY);
      run(0, 1'b0, 6, 16'h0000, 16'h0100, 9, 1'b1);
      run(2, 1'b1, 6, 16'h06F2, 16'h0400, 11, 1'b0);
      run(1, 1'b1, 3, 16'h001F, 16'h0008, 5, 1'b0);
      check("queue empty", exp_q.size(), 0);
      stop_test;
   end
endmodule

`default_nettype wire
